// ==== rsp_buf2.v ====
// Two-entry valid/ready buffer with registered ready
`timescale 1ns/10ps
module rsp_buf2 #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output reg          in_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  reg [W-1:0] d0;
  reg [W-1:0] d1;
  reg [1:0]   count;
  wire        push = in_valid & in_ready;
  wire        pop  = out_valid & out_ready;
  wire [1:0]  next_count = count + {1'b0, push} - {1'b0, pop};

  assign out_valid = (count != 2'd0);
  assign out_data  = d0;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      count    <= 2'd0;
      in_ready <= 1'b0;
      d0       <= {W{1'b0}};
      d1       <= {W{1'b0}};
    end
    else
    begin
      count    <= next_count;
      in_ready <= (next_count != 2'd2);
      if (push && (count == 2'd0 || (count == 2'd1 && pop)))
        d0 <= in_data;
      else if (pop)
        d0 <= d1;
      if (push && count == 2'd1 && !pop)
        d1 <= in_data;
    end
  end
endmodule

// ==== rsp_checker.sv ====
// Boundary assertions for the radio SPI port
`timescale 1ns/10ps
`include "rsp_regs.vh"
module rsp_checker (
  input wire       clk,
  input wire       rst_n,
  input wire       chip_select_low_n,
  input wire       general_output_one_oe,
  input wire       serial_tx_bit,
  input wire [7:0] tx_data,
  input wire       tx_valid,
  input wire       tx_ready,
  input wire       rx_ready,
  input wire [2:0] main_state,
  input wire       chip_rdy_n,
  input wire       asleep
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Sync lag of the select pin is allowed for in the count
  property p_oe_hold;
    (!chip_select_low_n) [*6] |-> general_output_one_oe;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("serial out undriven while selected");
  property p_txv_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_txv_hold: assert property (p_txv_hold) else $error("transmit byte dropped before taken");
  property p_sleep_rdy;
    asleep |=> chip_rdy_n;
  endproperty
  a_sleep_rdy: assert property (p_sleep_rdy) else $error("ready while asleep");
  property p_sleep_idle;
    asleep |-> main_state == `RSP_ST_IDLE;
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("asleep but state not idle");
  // Power-down only acts once select is high again
  property p_pd_waits;
    $rose(asleep) |-> $past(chip_select_low_n, 2);
  endproperty
  a_pd_waits: assert property (p_pd_waits) else $error("sleep entered while selected");
  property p_txser;
    serial_tx_bit |-> main_state == `RSP_ST_TX || $past(main_state) == `RSP_ST_TX;
  endproperty
  a_txser: assert property (p_txser) else $error("serial data passed outside transmit");
  property p_rx_rdy;
    $rose(rst_n) |-> ##[1:2] rx_ready;
  endproperty
  a_rx_rdy: assert property (p_rx_rdy) else $error("receive buffer not ready after reset");
  property p_rdy_rel;
    $rose(rst_n) |-> ##[1:3] !chip_rdy_n;
  endproperty
  a_rdy_rel: assert property (p_rdy_rel) else $error("not ready after reset");
  property p_state_legal;
    main_state inside {3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
  endproperty
  a_state_legal: assert property (p_state_legal) else $error("unknown main state code");
endmodule
bind rsp_radio_spi rsp_checker u_chk (.clk(clk), .rst_n(rst_n), .chip_select_low_n(chip_select_low_n),
  .general_output_one_oe(general_output_one_oe), .serial_tx_bit(serial_tx_bit), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_ready(rx_ready), .main_state(main_state),
  .chip_rdy_n(chip_rdy_n), .asleep(asleep));

// ==== rsp_host.sv ====
// Host microcontroller model on the SPI pins
`timescale 1ns/10ps
module rsp_host (
  input  wire       clk,
  input  wire       so,
  output reg        cs_n,
  output reg        sclk,
  output reg        si,
  output reg  [7:0] got,
  output reg        stb
);
  initial
  begin
    cs_n = 1;
    sclk = 0;
    si = 0;
    got = 0;
    stb = 0;
  end
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task sel(input reg v);
    cs_n = v;
  endtask
  task pins(input reg c, input reg d);
    begin
      sclk = c;
      si = d;
    end
  endtask
  // Ready shows as a low serial out before any clock pulse
  task wait_low(input integer lo, output reg ok);
    integer k;
    begin
      ok = 0;
      for (k = 0; k < 400 && !ok; k++)
      begin
        tick(1);
        ok = (k > lo) && (so === 1'b0);
      end
    end
  endtask
  // Mode 0, 64 ns clock period, MSB first
  task xbyte(input [7:0] b);
    integer i;
    begin
      for (i = 7; i >= 0; i--)
      begin
        si = b[i];
        tick(8);
        sclk = 1;
        got[i] = so;
        tick(8);
        sclk = 0;
      end
      stb = 1;
      tick(1);
      stb = 0;
    end
  endtask
  // Released data line flips so a stale bit cannot pass
  task stop;
    begin
      si = ~si;
      cs_n = 1;
      tick(8);
    end
  endtask
endmodule

// ==== rsp_radio_spi.v ====
// Serial configuration port: registers, strobes, FIFOs, power table
`timescale 1ns/10ps
module rsp_radio_spi (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       chip_select_low_n,
  input  wire       sclk,
  input  wire       si,
  output reg        general_output_one_out,
  output reg        general_output_one_oe,
  input  wire       general_output_zero_in,
  output reg        serial_tx_bit,
  output reg  [7:0] tx_data,
  output reg        tx_valid,
  input  wire       tx_ready,
  input  wire [7:0] rx_data,
  input  wire       rx_valid,
  output wire       rx_ready,
  output reg  [2:0] main_state,
  output reg        chip_rdy_n,
  output reg        asleep,
  output reg  [7:0] pa_setting
);
`include "rsp_regs.vh"
  localparam integer RESET_I   = `RSP_RESET_CYC;
  localparam integer WAKE_I    = `RSP_WAKE_CYC;
  localparam [7:0]   RESET_CYC = RESET_I[7:0];
  localparam [7:0]   WAKE_CYC  = WAKE_I[7:0];

  reg  [7:0] cfg [0:`RSP_CFG_LAST];
  reg  [7:0] pa  [0:7];
  reg  [7:0] txm [0:63];
  reg  [7:0] rxm [0:63];
  reg  [6:0] tx_wp;
  reg  [6:0] tx_rp;
  reg  [6:0] rx_wp;
  reg  [6:0] rx_rp;
  reg        cs_n_q;
  reg        sclk_q;
  reg        si_q;
  reg  [2:0] bit_cnt;
  reg  [6:0] sr_in;
  reg  [7:0] out_sr;
  reg        in_hdr;
  reg        rw;
  reg        burst;
  reg  [5:0] addr;
  reg  [2:0] pa_idx;
  reg        pd_pend;
  reg        pd_sleep;
  reg  [7:0] busy_cnt;
  wire [3:0] syn;
  wire [7:0] buf_data;
  wire       buf_valid;

  rsp_sync #(.W(4), .INIT(4'h1)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({general_output_zero_in, si, sclk, chip_select_low_n}),
    .dout  (syn)
  );

  wire       cs_n_s   = syn[0];
  wire       sclk_s   = syn[1];
  wire       si_s     = syn[2];
  wire       general_output_zero_s   = syn[3];
  wire       cs_act   = ~cs_n_s;
  wire       cs_fall  = cs_n_q & ~cs_n_s;
  wire       cs_rise  = ~cs_n_q & cs_n_s;
  wire       sck_rise = cs_act & sclk_s & ~sclk_q;
  wire       sck_fall = cs_act & ~sclk_s & sclk_q;
  wire       byte_end = sck_rise & (bit_cnt == 3'd7);
  wire [7:0] byte_w   = {sr_in, si_s};
  wire [5:0] h_a      = byte_w[5:0];
  wire [6:0] tx_cnt   = tx_wp - tx_rp;
  wire [6:0] rx_cnt   = rx_wp - rx_rp;
  wire       push_now = byte_end & ~in_hdr & ~rw & (addr == `RSP_FIFO_ADDR) &
                        (tx_cnt != `RSP_FIFO_FULL);
  wire [6:0] tx_used  = tx_cnt + {6'd0, push_now};
  wire       rdy_n    = asleep | (busy_cnt != 8'd0);
  wire       flush_ok = (main_state == `RSP_ST_IDLE) | (main_state == `RSP_ST_UND) |
                        (main_state == `RSP_ST_OVF);
  wire       buf_ready = (main_state == `RSP_ST_RX) & ~asleep & (rx_cnt != `RSP_FIFO_FULL);
  wire       pin_ctl  = cfg[`RSP_CFG_MCSM][`RSP_PIN_CTRL_BIT];

  rsp_buf2 #(.W(8)) u_rxbuf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (rx_data),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_ready)
  );

  // FIFO count field saturates at fifteen
  function [3:0] avail;
    input rdsel;
    reg [6:0] n;
    begin
      n = rdsel ? rx_cnt : (`RSP_FIFO_FULL - tx_used);
      avail = (n > `RSP_AVAIL_MAX) ? 4'hf : n[3:0];
    end
  endfunction

  function [7:0] status;
    input rdsel;
    begin
      status = {rdy_n, main_state, avail(rdsel)};
    end
  endfunction

  function [7:0] cfg_rd;
    input [5:0] a;
    begin
      cfg_rd = (a <= `RSP_CFG_LAST) ? cfg[a] : 8'h00;
    end
  endfunction

  function [7:0] stat_reg;
    input [5:0] a;
    begin
      if (a == `RSP_STAT_MAIN)
        stat_reg = {5'd0, main_state};
      else if (a == `RSP_STAT_TXFILL)
        stat_reg = {main_state == `RSP_ST_UND, tx_cnt};
      else if (a == `RSP_STAT_RXFILL)
        stat_reg = {main_state == `RSP_ST_OVF, rx_cnt};
      else
        stat_reg = 8'h00;
    end
  endfunction

  task flush_fifos;
    begin
      tx_wp <= 7'd0;
      tx_rp <= 7'd0;
      rx_wp <= 7'd0;
      rx_rp <= 7'd0;
    end
  endtask

  task init_all;
    integer i;
    begin
      for (i = 0; i <= `RSP_CFG_LAST; i = i + 1)
        cfg[i] <= 8'h00;
      cfg[`RSP_CFG_GENERAL_OUTPUT_ONE] <= `RSP_GENERAL_OUTPUT_ONE_RST;
      for (i = 0; i < 8; i = i + 1)
        pa[i] <= 8'h00;
      flush_fifos;
      main_state <= `RSP_ST_IDLE;
      asleep     <= 1'b0;
      pd_pend    <= 1'b0;
      pd_sleep   <= 1'b0;
      tx_valid   <= 1'b0;
      tx_data    <= 8'h00;
    end
  endtask

  // Read data for the coming byte; FIFO and table reads consume here
  task load_read;
    input [5:0] a;
    begin
      if (a == `RSP_PA_ADDR)
      begin
        out_sr <= pa[pa_idx];
        pa_idx <= pa_idx + 3'd1;
      end
      else if (a == `RSP_FIFO_ADDR)
      begin
        out_sr <= (rx_cnt != 7'd0) ? rxm[rx_rp[5:0]] : 8'h00;
        if (rx_cnt != 7'd0)
          rx_rp <= rx_rp + 7'd1;
      end
      else
        out_sr <= cfg_rd(a);
    end
  endtask

  task strobe;
    input [5:0] a;
    begin
      case (a)
        `RSP_S_RESET:
        begin
          init_all;
          busy_cnt <= RESET_CYC;
        end
        `RSP_S_XOFF:
        begin
          pd_pend  <= 1'b1;
          pd_sleep <= 1'b0;
        end
        `RSP_S_PWD:
        begin
          pd_pend  <= 1'b1;
          pd_sleep <= 1'b1;
        end
        `RSP_S_RX:
          main_state <= `RSP_ST_RX;
        `RSP_S_TX:
          main_state <= `RSP_ST_TX;
        `RSP_S_IDLE:
          main_state <= `RSP_ST_IDLE;
        `RSP_S_FRX:
          if (flush_ok)
          begin
            rx_wp <= 7'd0;
            rx_rp <= 7'd0;
            if (main_state == `RSP_ST_OVF)
              main_state <= `RSP_ST_IDLE;
          end
        `RSP_S_FTX:
          if (flush_ok)
          begin
            tx_wp <= 7'd0;
            tx_rp <= 7'd0;
            if (main_state == `RSP_ST_UND)
              main_state <= `RSP_ST_IDLE;
          end
        default:
          main_state <= main_state;
      endcase
    end
  endtask

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      init_all;
      cs_n_q   <= 1'b1;
      sclk_q   <= 1'b0;
      si_q     <= 1'b0;
      bit_cnt  <= 3'd0;
      sr_in    <= 7'd0;
      out_sr   <= 8'h00;
      in_hdr   <= 1'b1;
      rw       <= 1'b0;
      burst    <= 1'b0;
      addr     <= 6'd0;
      pa_idx   <= 3'd0;
      busy_cnt <= 8'd0;
      chip_rdy_n             <= 1'b1;
      general_output_one_out <= 1'b0;
      general_output_one_oe  <= 1'b0;
      serial_tx_bit          <= 1'b0;
      pa_setting             <= 8'h00;
    end
    else
    begin
      cs_n_q     <= cs_n_s;
      sclk_q     <= sclk_s;
      si_q       <= si_s;
      chip_rdy_n <= rdy_n;
      if (busy_cnt != 8'd0)
        busy_cnt <= busy_cnt - 8'd1;
      pa_setting <= pa[cfg[`RSP_CFG_FREND][`RSP_PWR_HI:`RSP_PWR_LO]];
      serial_tx_bit <= (cfg[`RSP_CFG_PKT][`RSP_PKT_MODE_HI:`RSP_PKT_MODE_LO] != 2'd0) &&
                       (main_state == `RSP_ST_TX) && general_output_zero_s;
      // Ready bit is live before the first header clock, so reset or wake shows high
      if (cs_act)
      begin
        general_output_one_oe  <= 1'b1;
        general_output_one_out <= (in_hdr && bit_cnt == 3'd0) ? rdy_n : out_sr[7];
      end
      else
      begin
        general_output_one_oe  <= (cfg[`RSP_CFG_GENERAL_OUTPUT_ONE] != `RSP_GENERAL_OUTPUT_ONE_RST);
        general_output_one_out <= (rx_cnt != 7'd0);
      end
      // Transmit FIFO drain toward the modem
      if (tx_valid && tx_ready)
        tx_valid <= 1'b0;
      if (main_state == `RSP_ST_TX && !asleep && (!tx_valid || tx_ready))
      begin
        if (tx_cnt != 7'd0)
        begin
          tx_data  <= txm[tx_rp[5:0]];
          tx_valid <= 1'b1;
          tx_rp    <= tx_rp + 7'd1;
        end
        else if (tx_ready)
          main_state <= `RSP_ST_UND;
      end
      // Receive FIFO fill; a full FIFO stalls the buffer then overflows
      if (buf_valid && buf_ready)
      begin
        rxm[rx_wp[5:0]] <= buf_data;
        rx_wp <= rx_wp + 7'd1;
      end
      else if (main_state == `RSP_ST_RX && buf_valid && rx_cnt == `RSP_FIFO_FULL)
        main_state <= `RSP_ST_OVF;
      if (!cs_act)
        pa_idx <= 3'd0;
      if (cs_fall)
      begin
        bit_cnt <= 3'd0;
        in_hdr  <= 1'b1;
        out_sr  <= status(1'b0);
        if (asleep)
        begin
          asleep     <= 1'b0;
          main_state <= `RSP_ST_IDLE;
          busy_cnt   <= WAKE_CYC;
        end
        // Pin strobes move state or schedule power-down; no restart of the current one
        if (pin_ctl)
        begin
          case ({sclk_q, si_q})
            2'b00:
            begin
              pd_pend  <= 1'b1;
              pd_sleep <= 1'b1;
            end
            2'b01:
              main_state <= `RSP_ST_TX;
            2'b10:
              main_state <= `RSP_ST_IDLE;
            default:
              main_state <= `RSP_ST_RX;
          endcase
        end
      end
      if (cs_rise && pd_pend)
      begin
        pd_pend    <= 1'b0;
        asleep     <= 1'b1;
        main_state <= `RSP_ST_IDLE;
        if (pd_sleep)
        begin
          flush_fifos;
          pa[1] <= 8'h00;
          pa[2] <= 8'h00;
          pa[3] <= 8'h00;
          pa[4] <= 8'h00;
          pa[5] <= 8'h00;
          pa[6] <= 8'h00;
          pa[7] <= 8'h00;
        end
      end
      if (sck_fall && bit_cnt != 3'd0)
        out_sr <= {out_sr[6:0], 1'b0};
      if (sck_rise)
      begin
        sr_in   <= {sr_in[5:0], si_s};
        bit_cnt <= bit_cnt + 3'd1;
        // Whole status refreshed so a strobe just executed shows its new state
        if (in_hdr && bit_cnt == 3'd0)
          out_sr <= {rdy_n, main_state, avail(si_s)};
      end
      if (byte_end && in_hdr)
      begin
        rw     <= byte_w[7];
        burst  <= byte_w[6];
        addr   <= h_a;
        in_hdr <= 1'b0;
        if (h_a >= `RSP_STROBE_FIRST && h_a <= `RSP_STROBE_LAST)
        begin
          if (!byte_w[6])
          begin
            in_hdr <= 1'b1;
            out_sr <= status(byte_w[7]);
            strobe(h_a);
          end
          else
          begin
            burst  <= 1'b0;
            out_sr <= stat_reg(h_a);
          end
        end
        else if (byte_w[7])
          load_read(h_a);
        else
          out_sr <= status(1'b0);
      end
      if (byte_end && !in_hdr)
      begin
        if (!rw)
        begin
          if (addr <= `RSP_CFG_LAST)
            cfg[addr] <= byte_w;
          else if (addr == `RSP_PA_ADDR)
          begin
            pa[pa_idx] <= byte_w;
            pa_idx     <= pa_idx + 3'd1;
          end
          else if (push_now)
          begin
            txm[tx_wp[5:0]] <= byte_w;
            tx_wp <= tx_wp + 7'd1;
          end
        end
        if (!burst)
        begin
          in_hdr <= 1'b1;
          out_sr <= status(rw);
        end
        else
        begin
          // Burst runs until select rises, one direction throughout
          if (addr <= `RSP_CFG_LAST)
            addr <= addr + 6'd1;
          if (rw)
            load_read((addr <= `RSP_CFG_LAST) ? addr + 6'd1 : addr);
          else
            out_sr <= status(1'b0);
        end
      end
      if (byte_end && !in_hdr && !burst && addr >= `RSP_STROBE_FIRST && addr <= `RSP_STROBE_LAST)
        out_sr <= status(1'b1);
    end
  end
endmodule

// ==== rsp_regs.vh ====
// Addresses, fields, reset values and timing of the radio SPI port
`ifndef RSP_REGS_VH
`define RSP_REGS_VH
`define RSP_CFG_LAST     6'h2e
`define RSP_STROBE_FIRST 6'h30
`define RSP_STROBE_LAST  6'h3d
`define RSP_PA_ADDR      6'h3e
`define RSP_FIFO_ADDR    6'h3f
`define RSP_S_RESET      6'h30
`define RSP_S_XOFF       6'h32
`define RSP_S_RX         6'h34
`define RSP_S_TX         6'h35
`define RSP_S_IDLE       6'h36
`define RSP_S_PWD        6'h39
`define RSP_S_FRX        6'h3a
`define RSP_S_FTX        6'h3b
`define RSP_STAT_MAIN    6'h35
`define RSP_STAT_TXFILL  6'h3a
`define RSP_STAT_RXFILL  6'h3b
`define RSP_CFG_GENERAL_OUTPUT_ONE     6'h01
`define RSP_GENERAL_OUTPUT_ONE_RST     8'h2e
`define RSP_CFG_PKT      6'h08
`define RSP_PKT_MODE_HI  5
`define RSP_PKT_MODE_LO  4
`define RSP_CFG_MCSM     6'h18
`define RSP_PIN_CTRL_BIT 1
`define RSP_CFG_FREND    6'h22
`define RSP_PWR_HI       2
`define RSP_PWR_LO       0
`define RSP_ST_IDLE      3'h0
`define RSP_ST_RX        3'h1
`define RSP_ST_TX        3'h2
`define RSP_ST_OVF       3'h6
`define RSP_ST_UND       3'h7
`define RSP_FIFO_FULL    7'd64
`define RSP_AVAIL_MAX    7'd15
`define RSP_CLK_NS       4
`define RSP_RESET_NS     200
`define RSP_WAKE_NS      400
`define RSP_RESET_CYC    ((`RSP_RESET_NS + `RSP_CLK_NS - 1) / `RSP_CLK_NS)
`define RSP_WAKE_CYC     ((`RSP_WAKE_NS + `RSP_CLK_NS - 1) / `RSP_CLK_NS)
`endif

// ==== rsp_sync.v ====
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module rsp_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta <= INIT;
      dout <= INIT;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// ==== tb_radio_spi_register_fifo_access.sv ====
// Self-checking bench for the radio SPI port
`timescale 1ns/10ps
`include "rsp_regs.vh"
module tb_radio_spi_register_fifo_access;
  reg         clk = 0;
  reg         rst_n;
  reg         tx_ready;
  reg  [7:0]  rx_data;
  reg         rx_valid;
  reg         gin;
  reg  [2:0]  gh;
  reg  [7:0]  a;
  wire        cs_n, sclk, si, so_out, so_oe, stb, rx_ready, tx_valid, serial_tx_bit, chip_rdy_n, asleep;
  wire [7:0]  got, tx_data, pa_setting;
  wire [2:0]  main_state;
  wire        so = so_oe ? so_out : 1'bz;
  integer     n_errors = 0;
  integer     checks = 0;
  integer     seed = 96766;
  integer     k;
  reg  [15:0] e;
  reg  [15:0] q[$];
  reg  [7:0]  txq[$];
  reg  [7:0]  v[0:8];
  reg  [7:0]  d;
  reg         ok;
  always #2 clk = ~clk;
  always @(posedge clk) #1 gin = $random(seed);
  // Serial data pin history; the port passes it on after sync and output flop
  always @(posedge clk) gh <= {gh[1:0], gin};
  rsp_radio_spi DUT (.clk(clk), .rst_n(rst_n), .chip_select_low_n(cs_n), .sclk(sclk), .si(si),
    .general_output_one_out(so_out), .general_output_one_oe(so_oe), .general_output_zero_in(gin),
    .serial_tx_bit(serial_tx_bit), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .main_state(main_state),
    .chip_rdy_n(chip_rdy_n), .asleep(asleep), .pa_setting(pa_setting));
  rsp_host host (.clk(clk), .so(so), .cs_n(cs_n), .sclk(sclk), .si(si), .got(got), .stb(stb));
  task check(input [7:0] g, input [7:0] x);
    begin
      checks++;
      if (g !== x)
      begin
        n_errors++;
        $display("[ERR] %0t got %h expected %h", $time, g, x);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task bad;
    begin
      n_errors++;
      $display("[ERR] %0t wait expired", $time);
      close_out;
    end
  endtask
  function [7:0] st(input [2:0] s, input [6:0] c);
    st = {1'b0, s, c > 15 ? 4'hf : c[3:0]};
  endfunction
  task b(input [7:0] t, input [7:0] m, input [7:0] x);
    begin
      q.push_back({m, x});
      host.xbyte(t);
    end
  endtask
  task fs;
    begin
      host.sel(0);
      host.wait_low(6, ok);
      if (!ok) bad;
    end
  endtask
  task rxsend(input [7:0] x);
    integer j;
    begin
      rx_data = x;
      rx_valid = 1;
      j = 0;
      @(posedge clk);
      while (!rx_ready && j < 50)
      begin
        @(posedge clk);
        j++;
      end
      #1 rx_valid = 0;
      if (j == 50) bad;
      host.tick(1);
    end
  endtask
  always @(posedge stb)
  begin
    e = q.pop_front();
    check(got & e[15:8], e[7:0]);
  end
  always @(posedge clk)
    if (tx_valid === 1'b1 && tx_ready) check(tx_data, txq.pop_front());
  initial
  begin
    rst_n = 0;
    tx_ready = 0;
    rx_valid = 0;
    rx_data = $random(seed);
    repeat (10) @(posedge clk);
    #1 rst_n = 1;
    host.tick(4);
    check({7'h0, chip_rdy_n}, 8'h00);
    fs;
    b(8'h30, 8'hff, st(0, 64));
    host.wait_low(60, ok);
    if (!ok) bad;
    b(8'h85, 8'hff, st(0, 0));
    b(8'h00, 8'hff, 8'h00);
    host.stop;
    check({7'h0, so_oe}, 8'h00);
    for (k = 0; k < 3; k++)
    begin
      a = k == 0 ? 8'h00 : k == 1 ? 8'h05 : 8'h2e;
      d = $random(seed);
      fs;
      b(a, 8'hff, st(0, 64));
      b(d, 8'hff, st(0, 64));
      b(a | 8'h80, 8'hff, st(0, 0));
      b(8'h00, 8'hff, d);
      host.stop;
    end
    fs;
    b(8'h50, 8'hff, st(0, 64));
    for (k = 0; k < 4; k++)
    begin
      v[k] = $random(seed);
      b(v[k], 8'hff, st(0, 64));
    end
    host.stop;
    fs;
    b(8'hd0, 8'hff, st(0, 0));
    for (k = 0; k < 4; k++) b(8'h00, 8'hff, v[k]);
    host.stop;
    // Test register opened for idle use, restored before leaving idle
    fs;
    b(8'h2e, 8'hff, st(0, 64));
    b(8'hbf, 8'hff, st(0, 64));
    b(8'h2e, 8'hff, st(0, 64));
    b(8'h7f, 8'hff, st(0, 64));
    host.stop;
    $display("test registers done");
    fs;
    b(8'h3f, 8'hff, st(0, 64));
    for (k = 0; k < 65; k++)
    begin
      if (k == 1) b(8'h7f, 8'hff, st(0, 63));
      d = $random(seed);
      if (k < 64) txq.push_back(d);
      b(d, 8'hff, st(0, 64 - k));
    end
    host.stop;
    fs;
    b(8'hfa, 8'hff, st(0, 0));
    b(8'h00, 8'hff, 8'h40);
    b(8'h35, 8'hff, st(0, 0));
    host.stop;
    tx_ready = 1;
    for (k = 0; k < 3000 && main_state !== `RSP_ST_UND; k++) host.tick(1);
    if (k == 3000) bad;
    tx_ready = 0;
    check({7'h0, txq.size() == 0}, 8'h01);
    fs;
    b(8'h3b, 8'hff, st(7, 64));
    b(8'hf5, 8'hff, st(0, 0));
    b(8'h00, 8'hff, 8'h00);
    b(8'h34, 8'hff, st(0, 64));
    host.stop;
    $display("test transmit done");
    for (k = 0; k < 5; k++)
    begin
      v[k] = $random(seed);
      rxsend(v[k]);
    end
    fs;
    b(8'h3a, 8'hff, st(1, 64));
    b(8'h36, 8'hff, st(1, 64));
    host.stop;
    fs;
    b(8'hbf, 8'hff, st(0, 5));
    b(8'h00, 8'hff, v[0]);
    b(8'hff, 8'hff, st(0, 4));
    for (k = 1; k < 5; k++) b(8'h00, 8'hff, v[k]);
    host.stop;
    fs;
    b(8'hbf, 8'hff, st(0, 0));
    b(8'h00, 8'hff, 8'h00);
    host.stop;
    $display("test receive done");
    fs;
    b(8'h7e, 8'hff, st(0, 64));
    for (k = 0; k < 9; k++)
    begin
      v[k] = $random(seed);
      b(v[k], 8'hff, st(0, 64));
    end
    host.stop;
    v[0] = v[8];
    fs;
    b(8'hfe, 8'hff, st(0, 0));
    for (k = 0; k < 8; k++) b(8'h00, 8'hff, v[k]);
    host.stop;
    fs;
    b(8'hbe, 8'hff, st(0, 0));
    b(8'h00, 8'hff, v[0]);
    b(8'hbe, 8'hff, st(0, 0));
    b(8'h00, 8'hff, v[1]);
    host.stop;
    for (k = 0; k < 8; k++)
    begin
      fs;
      b(8'h22, 8'hff, st(0, 64));
      b(k[7:0], 8'hff, st(0, 64));
      host.stop;
      check(pa_setting, v[k]);
    end
    $display("test power table done");
    fs;
    b(8'h7f, 8'hff, st(0, 64));
    b(8'h11, 8'hff, st(0, 64));
    b(8'h22, 8'hff, st(0, 63));
    host.stop;
    fs;
    b(8'h39, 8'hff, st(0, 62));
    host.tick(20);
    check({7'h0, asleep}, 8'h00);
    host.stop;
    check({7'h0, asleep}, 8'h01);
    fs;
    b(8'hfa, 8'hff, st(0, 0));
    b(8'h00, 8'hff, 8'h00);
    b(8'hbe, 8'hff, st(0, 0));
    b(8'h00, 8'hff, v[0]);
    host.stop;
    fs;
    b(8'h32, 8'hff, st(0, 64));
    host.tick(20);
    check({7'h0, asleep}, 8'h00);
    host.stop;
    check({7'h0, asleep}, 8'h01);
    check({7'h0, chip_rdy_n}, 8'h01);
    $display("test sleep done");
    fs;
    b(8'h08, 8'hff, st(0, 64));
    b(8'h10, 8'hff, st(0, 64));
    b(8'h18, 8'hff, st(0, 64));
    b(8'h02, 8'hff, st(0, 64));
    host.stop;
    for (k = 0; k < 4; k++)
    begin
      d = k == 0 ? 8'h01 : k == 1 ? 8'h03 : k == 2 ? 8'h02 : 8'h00;
      host.pins(d[1], d[0]);
      host.tick(6);
      host.sel(0);
      host.tick(12);
      check({4'h0, asleep, main_state}, k == 0 ? 8'h02 : k == 1 ? 8'h01 : 8'h00);
      check({7'h0, serial_tx_bit}, {7'h0, gh[2] & (k == 0)});
      host.sel(1);
      host.tick(12);
    end
    check({7'h0, asleep}, 8'h01);
    $display("test pin control done");
    close_out;
  end
endmodule
